/* File: verilog/clk_status_pkg.sv */
// Summary of operation
// - Bit 6 shows on-chip oscillator reference
// - Bit 5 shows crystal reference
// - Sticky lock sets on lock after multiplier change or fast-wakeup stop
// - Loss of lock clears sticky flag until rearmed
// - Stop holds sticky lock; fast wakeup clears it
// - Sticky lock reset: clear external, set PLL modes
// - Live lock follows analog lock window
// - Live lock gates power-on reset release
// - External mode keeps live lock clear
// - Bit 2 sticky loss-of-clock flag
// - Fast-wakeup full stop sets flag during wakeup
// - Detection needs enable or unrecovered oscillator
// - External mode forces loss-of-clock zero
// - Four-bit divider divides by two power n
// - New divider acts at next clock edge
// - Gate bits 11..7 stop peripheral clocks
// - Gate bits 4..3 stop interval timers
// - Gate bits 1..0 stop edge port, gpio
// - Status register is read-only, writes ignored
// - Wakeup clock enable per fast wakeup and lock
// - Bit 7 shows external oscillator reference
package clk_status_pkg;
	localparam logic [3:0]  ADDR_STATUS   = 4'h0;
	localparam logic [3:0]  ADDR_LOW_PWR  = 4'h4;
	localparam logic [3:0]  ADDR_GATE_HI  = 4'h8;
	localparam logic [3:0]  ADDR_CTRL     = 4'hc;
	localparam int          ST_EXT_OSC    = 7;
	localparam int          ST_ONCHIP     = 6;
	localparam int          ST_CRYSTAL    = 5;
	localparam int          ST_STICKY_PLL_LOCKED      = 4;
	localparam int          ST_LOCK       = 3;
	localparam int          ST_LOSS_OF_CLOCK_STICKY       = 2;
	localparam logic [31:0] GATE_MASK     = 32'h0000_0f9b;
	localparam logic [31:0] GATE_RESET    = 32'h0000_0000;
	localparam logic [3:0]  LPD_RESET     = 4'h0;
	localparam int          CTRL_MFD_LSB  = 0;
	localparam int          CTRL_CLOCK_LOSS_ENABLE    = 3;
	localparam int          CTRL_FAST_WAKEUP    = 4;
	localparam int          CTRL_STOP_MODE_SELECT_LSB = 5;
	localparam logic [1:0]  STOP_MODE_SELECT_ALL_OFF = 2'b11;
	localparam logic [7:0]  CTRL_RESET    = 8'h00;

	typedef enum logic [1:0] {
		MODE_EXT,
		MODE_ONE_TO_ONE,
		MODE_NORMAL
	} clk_mode_e;

	typedef struct packed {
		logic ext_osc;
		logic onchip_osc;
		logic crystal;
		logic pll_lock;
		logic clock_fail;
		logic osc_running;
	} analog_status_s;

	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_s;
endpackage

/* File: verilog/pll_status_and_clock_gating.sv */
`timescale 1ns/1ps
`default_nettype none
module pll_status_and_clock_gating (
	input  wire logic                            clk,
	input  wire logic                            resetn,
	input  wire clk_status_pkg::clk_mode_e       clock_mode,
	input  wire clk_status_pkg::analog_status_s  analog_in,
	input  wire logic                            stop_mode,
	input  wire clk_status_pkg::reg_req_s        bus_req,
	output logic [31:0]                          rdata,
	output logic [31:0]                          periph_clock_gate_high,
	output logic [3:0]                           low_power_divider,
	output logic [15:0]                          sys_div_ratio,
	output logic                                 por_release_ok,
	output logic                                 sys_clk_enable,
	output logic [7:0]                           synth_control
);
	import clk_status_pkg::*;

	analog_status_s sync1_reg;
	analog_status_s sync2_reg;
	clk_mode_e      mode_reg;
	logic           mode_valid_reg;
	logic           lock_reg;
	logic           sticky_pll_locked;
	logic           lock_armed_reg;
	logic           loss_of_clock_sticky;
	logic           wake_fast_reg;
	logic           stop_d_reg;
	logic [7:0]     status_reg;
	logic [2:0]     multiplier_field;
	logic           clock_loss_enable;
	logic           fast_wakeup;
	logic [1:0]     stop_mode_select;
	logic           lock_fall;
	logic           loc_detect_ok;
	logic           wr_ctrl;
	logic           mfd_change;

	// One decode for every register write strobe
	function automatic logic write_hits(input reg_req_s req, input logic [3:0] addr);
		return req.wr && req.addr == addr;
	endfunction

	// Analog flags come from other clock domains
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= analog_in;
			sync2_reg <= sync1_reg;
		end
	end

	// Strap is caught after reset release, never under reset itself
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode_reg       <= MODE_EXT;
			mode_valid_reg <= 1'b0;
		end else if (!mode_valid_reg) begin
			mode_reg       <= clock_mode;
			mode_valid_reg <= 1'b1;
		end
	end

	assign multiplier_field  = synth_control[CTRL_MFD_LSB +: 3];
	assign clock_loss_enable = synth_control[CTRL_CLOCK_LOSS_ENABLE];
	assign fast_wakeup       = synth_control[CTRL_FAST_WAKEUP];
	assign stop_mode_select  = synth_control[CTRL_STOP_MODE_SELECT_LSB +: 2];
	assign wr_ctrl = write_hits(bus_req, ADDR_CTRL);
	// Of control writes, only a change of the multiplier rearms; rewriting the same value does not
	assign mfd_change = wr_ctrl && bus_req.wdata[CTRL_MFD_LSB +: 3] != multiplier_field;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			synth_control <= CTRL_RESET;
		else if (wr_ctrl)
			synth_control <= bus_req.wdata[7:0];
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			lock_reg <= 1'b0;
		else
			lock_reg <= (mode_reg != MODE_EXT) && sync2_reg.pll_lock;
	end
	assign lock_fall = lock_reg && !sync2_reg.pll_lock;

	// Tracks stop entry and fast wakeup exit
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stop_d_reg    <= 1'b0;
			wake_fast_reg <= 1'b0;
		end else begin
			stop_d_reg <= stop_mode;
			if (stop_d_reg && !stop_mode && fast_wakeup &&
			    stop_mode_select == STOP_MODE_SELECT_ALL_OFF)
				wake_fast_reg <= 1'b1;
			else if (sync2_reg.osc_running)
				wake_fast_reg <= 1'b0;
		end
	end

	// Armed by a multiplier change or fast wakeup; the next lock sets the flag
	// and disarms, so a later loss keeps the flag clear across relock.
	// A loss while still armed is the expected relock transient and keeps the arm.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lock_armed_reg    <= 1'b1;
			sticky_pll_locked <= 1'b0;
		end else if (!mode_valid_reg) begin
			sticky_pll_locked <= (clock_mode != MODE_EXT);
			lock_armed_reg    <= 1'b0;
		end else if (mode_reg == MODE_EXT) begin
			sticky_pll_locked <= 1'b0;
		end else if (mfd_change) begin
			lock_armed_reg    <= 1'b1;
			sticky_pll_locked <= 1'b0;
		end else if (stop_mode && !fast_wakeup) begin
			sticky_pll_locked <= sticky_pll_locked;
		end else if (stop_mode && fast_wakeup) begin
			sticky_pll_locked <= 1'b0;
			lock_armed_reg    <= 1'b1;
		end else if (lock_fall) begin
			sticky_pll_locked <= 1'b0;
		end else if (lock_armed_reg && lock_reg) begin
			sticky_pll_locked <= 1'b1;
			lock_armed_reg    <= 1'b0;
		end
	end

	assign loc_detect_ok = clock_loss_enable || wake_fast_reg;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			loss_of_clock_sticky <= 1'b0;
		else if (mode_reg == MODE_EXT)
			loss_of_clock_sticky <= 1'b0;
		else if (wake_fast_reg && !sync2_reg.osc_running)
			loss_of_clock_sticky <= 1'b1;
		else if (loc_detect_ok && sync2_reg.clock_fail)
			loss_of_clock_sticky <= 1'b1;
		else if (wake_fast_reg && sync2_reg.osc_running)
			loss_of_clock_sticky <= 1'b0;
	end

	always_comb begin
		status_reg             = '0;
		status_reg[ST_EXT_OSC] = sync2_reg.ext_osc;
		status_reg[ST_ONCHIP]  = sync2_reg.onchip_osc;
		status_reg[ST_CRYSTAL] = sync2_reg.crystal;
		status_reg[ST_STICKY_PLL_LOCKED]   = sticky_pll_locked;
		status_reg[ST_LOCK]    = lock_reg;
		status_reg[ST_LOSS_OF_CLOCK_STICKY]    = loss_of_clock_sticky;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			low_power_divider <= LPD_RESET;
			sys_div_ratio     <= 16'h0001;
		end else begin
			if (write_hits(bus_req, ADDR_LOW_PWR))
				low_power_divider <= bus_req.wdata[3:0];
			sys_div_ratio <= 16'h0001 << low_power_divider;
		end
	end

	// Reserved bits are held at zero whatever software writes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			periph_clock_gate_high <= GATE_RESET;
		else if (write_hits(bus_req, ADDR_GATE_HI))
			periph_clock_gate_high <= bus_req.wdata & GATE_MASK;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			por_release_ok <= 1'b0;
			sys_clk_enable <= 1'b0;
		end else begin
			por_release_ok <= (mode_reg == MODE_EXT) || lock_reg;
			sys_clk_enable <= !stop_mode &&
			                  (fast_wakeup || lock_reg || mode_reg == MODE_EXT);
		end
	end

	// Status writes fall through the decode untouched
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rdata <= '0;
		else if (bus_req.rd) begin
			case (bus_req.addr)
				ADDR_STATUS:  rdata <= {24'h0, status_reg};
				ADDR_LOW_PWR: rdata <= {28'h0, low_power_divider};
				ADDR_GATE_HI: rdata <= periph_clock_gate_high;
				ADDR_CTRL:    rdata <= {24'h0, synth_control};
				default:      rdata <= '0;
			endcase
		end else
			rdata <= '0;
	end

	property p_lock_fall_clears;
		@(posedge clk) disable iff (!resetn)
		(lock_fall && mode_valid_reg && !stop_mode && !wr_ctrl) |=> !sticky_pll_locked;
	endproperty
	a_sticky_pll_locked_loss_clear: assert property (p_lock_fall_clears)
		else $error("sticky lock not cleared on loss");

	a_loss_of_clock_sticky_ext_zero: assert property (@(posedge clk) disable iff (!resetn)
		(mode_reg == MODE_EXT) |=> !loss_of_clock_sticky)
		else $error("loss flag set in external mode");

	a_gate_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
		(periph_clock_gate_high & ~GATE_MASK) == 32'h0)
		else $error("reserved gate bits set");

	a_lpd_write_next: assert property (@(posedge clk) disable iff (!resetn)
		(bus_req.wr && bus_req.addr == ADDR_LOW_PWR) |=>
		low_power_divider == $past(bus_req.wdata[3:0]))
		else $error("divider write not applied");

	a_div_ratio: assert property (@(posedge clk) disable iff (!resetn)
		##1 sys_div_ratio == (16'h0001 << $past(low_power_divider)))
		else $error("divide ratio wrong");

	a_lock_ext_clear: assert property (@(posedge clk) disable iff (!resetn)
		(mode_reg == MODE_EXT) |=> !lock_reg)
		else $error("live lock set in external mode");

	sequence s_clock_loss_enable_fail;
		clock_loss_enable && sync2_reg.clock_fail && mode_reg != MODE_EXT;
	endsequence
	a_loss_of_clock_sticky_on_fail: assert property (@(posedge clk) disable iff (!resetn)
		s_clock_loss_enable_fail ##1 (mode_reg != MODE_EXT) |-> loss_of_clock_sticky)
		else $error("loss of clock not flagged");

	a_status_read: assert property (@(posedge clk) disable iff (!resetn)
		(bus_req.rd && bus_req.addr == ADDR_STATUS) |=> rdata[31:8] == 24'h0)
		else $error("status upper bits nonzero");

	// Synchroniser holds reset values for two edges after release
	a_status_sync: assert property (@(posedge clk) disable iff (!resetn)
		($past(resetn) && $past(resetn, 2)) |->
		status_reg[ST_ONCHIP] == $past(analog_in.onchip_osc, 2))
		else $error("on-chip flag not two-stage synced");

	sequence s_pll_running;
		mode_valid_reg && mode_reg != MODE_EXT && !mfd_change;
	endsequence

	sequence s_armed_lock;
		!stop_mode && !lock_fall && lock_armed_reg && lock_reg;
	endsequence

	a_sticky_pll_locked_set_lock: assert property (@(posedge clk) disable iff (!resetn)
		(s_pll_running and s_armed_lock) |=> sticky_pll_locked)
		else $error("sticky lock not set on lock");

	a_stop_holds_lock: assert property (@(posedge clk) disable iff (!resetn)
		(s_pll_running and (stop_mode && !fast_wakeup)) |=> $stable(sticky_pll_locked))
		else $error("sticky lock changed in stop");

	a_fast_stop_clear: assert property (@(posedge clk) disable iff (!resetn)
		(s_pll_running and (stop_mode && fast_wakeup)) |=> !sticky_pll_locked)
		else $error("sticky lock not cleared in fast stop");

	a_live_lock_follow: assert property (@(posedge clk) disable iff (!resetn)
		(mode_reg != MODE_EXT) |=> lock_reg == $past(sync2_reg.pll_lock))
		else $error("live lock does not follow analog lock");

	a_por_on_lock: assert property (@(posedge clk) disable iff (!resetn)
		(mode_reg == MODE_EXT || lock_reg) |=> por_release_ok)
		else $error("reset release not granted on lock");

	a_loss_of_clock_sticky_stays_set: assert property (@(posedge clk) disable iff (!resetn)
		(loss_of_clock_sticky && mode_reg != MODE_EXT && !wake_fast_reg) |=>
		loss_of_clock_sticky)
		else $error("loss flag not sticky");

	a_wake_loss_of_clock_sticky_set: assert property (@(posedge clk) disable iff (!resetn)
		(mode_reg != MODE_EXT && wake_fast_reg && !sync2_reg.osc_running) |=>
		loss_of_clock_sticky)
		else $error("loss flag not set during wakeup");

	a_gate_write: assert property (@(posedge clk) disable iff (!resetn)
		write_hits(bus_req, ADDR_GATE_HI) |=>
		periph_clock_gate_high == ($past(bus_req.wdata) & GATE_MASK))
		else $error("gate write not applied");

	a_slow_wake_wait: assert property (@(posedge clk) disable iff (!resetn)
		(!fast_wakeup && mode_reg != MODE_EXT && !lock_reg) |=> !sys_clk_enable)
		else $error("clocks enabled before lock");

	a_ctrl_write: assert property (@(posedge clk) disable iff (!resetn)
		wr_ctrl |=> synth_control == $past(bus_req.wdata[7:0]))
		else $error("control write not applied");

	// Read data must not linger beyond its one cycle
	a_rdata_idle: assert property (@(posedge clk) disable iff (!resetn)
		!bus_req.rd |=> rdata == 32'h0)
		else $error("read data stands too long");

	a_wake_enable: assert property (@(posedge clk) disable iff (!resetn)
		(!stop_mode && fast_wakeup) |=> sys_clk_enable)
		else $error("fast wakeup did not enable clocks");
endmodule
`default_nettype wire

/* File: testbench/test_pll_status_and_clock_gating.sv */
`timescale 1ns/1ps
`default_nettype none
module test_pll_status_and_clock_gating;
	import clk_status_pkg::*;
	logic           clk;
	logic           resetn;
	clk_mode_e      clock_mode;
	analog_status_s analog_in;
	logic           stop_mode;
	reg_req_s       bus_req;
	logic [31:0]    rdata;
	logic [31:0]    periph_clock_gate_high;
	logic [3:0]     low_power_divider;
	logic [15:0]    sys_div_ratio;
	logic           por_release_ok;
	logic           sys_clk_enable;
	logic [7:0]     synth_control;
	int             miscompares;
	int             n_tests;
	int             cycles;
	logic [31:0]    got;
	// Gate rows: written value beside the value that must read back
	logic [31:0]    gate_in [5] = '{32'hffff_ffff, 32'h0000_0f80, 32'h0000_0018, 32'h0000_0003, 32'h0000_0064};
	logic [31:0]    gate_exp [5] = '{32'h0000_0f9b, 32'h0000_0f80, 32'h0000_0018, 32'h0000_0003, 32'h0000_0000};

	pll_status_and_clock_gating u_dut (
		.clk                    (clk),
		.resetn                 (resetn),
		.clock_mode             (clock_mode),
		.analog_in              (analog_in),
		.stop_mode              (stop_mode),
		.bus_req                (bus_req),
		.rdata                  (rdata),
		.periph_clock_gate_high (periph_clock_gate_high),
		.low_power_divider      (low_power_divider),
		.sys_div_ratio          (sys_div_ratio),
		.por_release_ok         (por_release_ok),
		.sys_clk_enable         (sys_clk_enable),
		.synth_control          (synth_control)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// A hang in any wait below is cut off here
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			miscompares = miscompares + 1;
			close_out();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
			miscompares = miscompares + 1;
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic do_reset(input clk_mode_e m, input analog_status_s a);
		@(posedge clk);
		resetn <= 1'b0;
		clock_mode <= m;
		analog_in <= a;
		wait_n(6);
		resetn <= 1'b1;
		wait_n(6);
	endtask

	initial begin
		resetn = 1'b0;
		clock_mode = MODE_NORMAL;
		analog_in = 6'b010101;
		stop_mode = 1'b0;
		bus_req = '0;
		miscompares = 0;
		n_tests = 0;
		cycles = 0;
		do_reset(MODE_NORMAL, 6'b010101);
		rd(ADDR_STATUS, got);
		chk("status after reset", 32'h58, got);
		chk("por release", 32'h1, {31'h0, por_release_ok});
		wr(ADDR_STATUS, 32'hff);
		rd(ADDR_STATUS, got);
		chk("status after write", 32'h58, got);
		rd(4'h2, got);
		chk("unmapped read", 32'h0, got);
		$display("test reset_status done");
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_GATE_HI, gate_in[i]);
			rd(ADDR_GATE_HI, got);
			chk("gate readback", gate_exp[i], got);
			chk("gate port", gate_exp[i], periph_clock_gate_high);
		end
		$display("test gate_rows done");
		for (int n = 0; n < 16; n++) begin
			wr(ADDR_LOW_PWR, 32'(n));
			#1 chk("divider field", 32'(n), {28'h0, low_power_divider});
			@(posedge clk);
			#1 chk("divide ratio", 32'h1 << n, {16'h0, sys_div_ratio});
		end
		rd(ADDR_LOW_PWR, got);
		chk("divider readback", 32'hf, got);
		$display("test divider done");
		analog_in.pll_lock <= 1'b0;
		wait_n(6);
		rd(ADDR_STATUS, got);
		chk("lock lost", 32'h40, got);
		analog_in.pll_lock <= 1'b1;
		wait_n(6);
		rd(ADDR_STATUS, got);
		chk("relock stays clear", 32'h48, got);
		analog_in.pll_lock <= 1'b0;
		wr(ADDR_CTRL, 32'h01);
		analog_in.pll_lock <= 1'b1;
		wait_n(6);
		rd(ADDR_STATUS, got);
		chk("lock after multiplier", 32'h58, got);
		$display("test sticky_lock done");
		stop_mode <= 1'b1;
		wait_n(3);
		chk("clock off in stop", 32'h0, {31'h0, sys_clk_enable});
		analog_in.pll_lock <= 1'b0;
		wait_n(6);
		stop_mode <= 1'b0;
		wait_n(6);
		chk("slow wakeup waits", 32'h0, {31'h0, sys_clk_enable});
		analog_in.pll_lock <= 1'b1;
		wait_n(6);
		chk("slow wakeup locked", 32'h1, {31'h0, sys_clk_enable});
		rd(ADDR_STATUS, got);
		chk("stop holds sticky", 32'h58, got);
		wr(ADDR_CTRL, 32'h71);
		#1 chk("control port", 32'h71, {24'h0, synth_control});
		rd(ADDR_CTRL, got);
		chk("control readback", 32'h71, got);
		stop_mode <= 1'b1;
		analog_in <= 6'b010000;
		wait_n(6);
		stop_mode <= 1'b0;
		wait_n(6);
		chk("fast wakeup clocks", 32'h1, {31'h0, sys_clk_enable});
		rd(ADDR_STATUS, got);
		chk("fast wakeup flags", 32'h44, got);
		analog_in <= 6'b010101;
		wait_n(8);
		rd(ADDR_STATUS, got);
		chk("osc recovered", 32'h58, got);
		$display("test stop_wakeup done");
		wr(ADDR_CTRL, 32'h01);
		analog_in.clock_fail <= 1'b1;
		wait_n(4);
		analog_in.clock_fail <= 1'b0;
		wait_n(4);
		rd(ADDR_STATUS, got);
		chk("loss ignored", 32'h58, got);
		wr(ADDR_CTRL, 32'h09);
		analog_in.clock_fail <= 1'b1;
		wait_n(4);
		analog_in.clock_fail <= 1'b0;
		wait_n(4);
		rd(ADDR_STATUS, got);
		chk("loss sticky", 32'h5c, got);
		$display("test loss_of_clock done");
		do_reset(MODE_EXT, 6'b100110);
		wr(ADDR_CTRL, 32'h08);
		wait_n(4);
		rd(ADDR_STATUS, got);
		chk("external status", 32'h80, got);
		chk("external por", 32'h1, {31'h0, por_release_ok});
		do_reset(MODE_ONE_TO_ONE, 6'b001101);
		rd(ADDR_STATUS, got);
		chk("one to one status", 32'h38, got);
		$display("test clock_modes done");
		close_out();
	end
endmodule
`default_nettype wire
